/* File: hw/ecr_pkg.sv */
/*
 Constants and types for the host-side clock and reset controller of an
 Ethernet MAC/PCS subsystem. Assumes a single 125 MHz controller clock.
*/
// Notes on behaviour
// [RULE1] PCS-only device outputs its transmit media clock, equal to serializer reference.
// [RULE2] Integrator picks line reference so transmit clock is within 100 ppm.
// [RULE3] PCS-only transmit signals are timed to the transmit media clock.
// [RULE4] Device processes receive data on recovered clock, outputs same-rate status clock.
// [RULE5] Client supplies receive media clock, within 100 ppm of nominal rate.
// [RULE6] A stable init clock feeds start-up helpers, configured with its real frequency.
// [RULE7] With MAC, transmit user clock times stream input and transmit status.
// [RULE8] Receive core user clock must be at least the transmit user clock rate.
// [RULE9] With receive FIFO, client should tie transmit user clock to receive core clock.
// [RULE10] Low-latency receive stream runs on unrelated receive status clock.
// [RULE11] Low-latency client must answer transmit ready in the same cycle.
// [RULE12] Negotiation frames made on serializer clock, received data on recovered clock.
// [RULE13] Negotiation logic runs on any clock whose real frequency is configured in.
// [RULE14] Negotiation logic exists only for backplane or copper options, independent domains.
// [RULE15] Device has separate transmit and receive resets, each assertable independently.
// [RULE16] Each reset stays asserted until its clock is fully stable.
// [RULE17] Device tolerates any order of asserting and releasing its resets.
// [RULE18] Change reset-only controls only while both path resets are held asserted.
// [RULE19] Resets are active high, synchronous, and need a clock edge while held.
// [RULE20] Asynchronous mode clocks helpers from transceiver transmit and receive clocks.
// [RULE21] Low-latency uses two datapath domains, other arrangements use three.
package ecr_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 8000;
	localparam int RESET_HOLD_NS = 100;
	localparam int SETTLE_US = 10;
	localparam int HOLD_CYC = (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SETTLE_CYC = (SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = 11;
	localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);
	localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);

	// ------------------------------------------------------------
	// Paths, controls and configuration
	// ------------------------------------------------------------
	localparam int TX_IDX = 0;
	localparam int RX_IDX = 1;
	localparam int CTL_W = 8;
	localparam logic [CTL_W-1:0] CTL_RESET = 8'h00;
	localparam logic [31:0] INIT_CLK_HZ = 32'h047868C0;
	localparam logic [31:0] NEG_CLK_HZ = 32'h047868C0;

	typedef enum logic [3:0] {
		C_IDLE = 4'h1,
		C_HOLD = 4'h2,
		C_APPLY = 4'h4,
		C_WAIT = 4'h8
	} ecr_ctl_state_type;

	typedef struct packed {
		logic [1:0] rst;
		logic [1:0][CNT_W-1:0] cnt;
		ecr_ctl_state_type cst;
		logic [CNT_W-1:0] ccnt;
		logic [CTL_W-1:0] ctl;
		logic [CTL_W-1:0] pend;
	} ecr_state_type;

	typedef struct packed {
		logic [2:0] f;
		logic lvl;
	} ecr_sync_state_type;

endpackage

/* File: hw/ecr_sync_if.sv */
/*
 Carrier between the controller and its pin synchronisers.
 Assumes the raw level is asynchronous to the controller clock.
*/
interface ecr_sync_if;
	logic raw;
	logic lvl;
	modport sync (input raw, output lvl);
	modport user (output raw, input lvl);
endinterface

/* File: hw/ecr_sync3.sv */
/*
 Three-stage synchroniser for one asynchronous level.
 Assumes the caller freezes it with the shared clock enable.
*/
module ecr_sync3
	import ecr_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// Level
	ecr_sync_if.sync s
);
	import ecr_pkg::*;

	ecr_sync_state_type q, d;

	// ------------------------------------------------------------
	// Filter
	// ------------------------------------------------------------
	// The first stage feeds only the second; a change counts once stages two and three agree.
	always_comb begin
		d = q;
		d.f = {q.f[1:0], s.raw};
		if (q.f[1] == q.f[2]) begin
			d.lvl = q.f[2];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign s.lvl = q.lvl;
endmodule

/* File: hw/ecr_host_ctrl.sv */
/*
 Host-side reset sequencer for the transmit and receive paths of the
 subsystem, plus a controlled update of its reset-only control inputs.
 Assumes clock-stable indicators arrive as asynchronous levels.
*/
module ecr_host_ctrl
	import ecr_pkg::*;
(
	// Clock, reset, enable
	input wire logic CLK,
	input wire logic RESET,
	input wire logic CE,
	// Clock-stable indicators from the device side
	input wire logic TX_CLK_STABLE,
	input wire logic RX_CLK_STABLE,
	// Control update request
	input wire logic CTL_REQ,
	input wire logic [ecr_pkg::CTL_W-1:0] CTL_VALUE,
	output logic CTL_BUSY,
	// Device resets and controls
	output logic TX_RESET,
	output logic RX_RESET,
	output logic [ecr_pkg::CTL_W-1:0] CTL_OUT,
	// Status
	output logic TX_READY,
	output logic RX_READY,
	// Static configuration
	output logic [31:0] INIT_CLK_FREQ,
	output logic [31:0] NEG_CLK_FREQ,
	output logic CLK_TIE_SEL
);
	import ecr_pkg::*;

	ecr_state_type q, d;
	logic [1:0] stable;
	logic force_rst;

	// ------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------
	ecr_sync_if tx_s ();
	ecr_sync_if rx_s ();
	assign tx_s.raw = TX_CLK_STABLE;
	assign rx_s.raw = RX_CLK_STABLE;

	ecr_sync3 u_tx_sync (
		.clk(CLK),
		.reset(RESET),
		.ce(CE),
		.s(tx_s.sync)
	);
	ecr_sync3 u_rx_sync (
		.clk(CLK),
		.reset(RESET),
		.ce(CE),
		.s(rx_s.sync)
	);
	assign stable = {rx_s.lvl, tx_s.lvl}; // RULE2 RULE5

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Both paths are held while a control update runs, which is harmless since the
	// device accepts resets in any order.
	always_comb begin
		d = q;
		force_rst = (q.cst != C_IDLE);
		for (int i = 0; i < 2; i++) begin
			if (!stable[i] || force_rst) begin
				d.rst[i] = 1'b1; // RULE16
				d.cnt[i] = '0;
			end else if (q.rst[i]) begin
				if (q.cnt[i] == SETTLE_LAST) begin
					d.rst[i] = 1'b0; // RULE19
				end else begin
					d.cnt[i] = q.cnt[i] + 1'b1;
				end
			end
		end
		case (q.cst)
			C_IDLE: begin
				if (CTL_REQ) begin
					d.pend = CTL_VALUE;
					d.rst = 2'b11; // RULE18
					d.ccnt = '0;
					d.cst = C_HOLD;
				end
			end
			C_HOLD: begin
				if (q.ccnt == HOLD_LAST) begin
					d.cst = C_APPLY;
				end else begin
					d.ccnt = q.ccnt + 1'b1;
				end
			end
			C_APPLY: begin
				d.ctl = q.pend; // RULE18
				d.ccnt = '0;
				d.cst = C_WAIT;
			end
			C_WAIT: begin
				if (q.ccnt == HOLD_LAST) begin
					d.cst = C_IDLE;
				end else begin
					d.ccnt = q.ccnt + 1'b1;
				end
			end
			default: begin
				d.cst = C_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			q.rst <= 2'b11;
			q.cnt <= '0;
			q.cst <= C_IDLE;
			q.ccnt <= '0;
			q.ctl <= CTL_RESET;
			q.pend <= CTL_RESET;
		end else if (CE) begin
			q <= d; // RULE3
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign TX_RESET = q.rst[TX_IDX]; // RULE15
	assign RX_RESET = q.rst[RX_IDX]; // RULE15
	assign CTL_OUT = q.ctl;
	assign CTL_BUSY = (q.cst != C_IDLE); // RULE11
	assign TX_READY = !q.rst[TX_IDX];
	assign RX_READY = !q.rst[RX_IDX];
	assign INIT_CLK_FREQ = INIT_CLK_HZ; // RULE6
	assign NEG_CLK_FREQ = NEG_CLK_HZ; // RULE13
	// Sharing one user clock keeps both stream interfaces in a single domain.
	assign CLK_TIE_SEL = 1'b1; // RULE8 RULE9

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [CNT_W-1:0] tx_held, rx_held;
	always_ff @(posedge CLK) begin
		if (RESET) begin
			tx_held <= '0;
			rx_held <= '0;
		end else if (CE) begin
			tx_held <= TX_RESET ? ((&tx_held) ? tx_held : tx_held + 1'b1) : '0;
			rx_held <= RX_RESET ? ((&rx_held) ? rx_held : rx_held + 1'b1) : '0;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET || !CE);

	property p_tx_unstable;
		!stable[TX_IDX] |=> TX_RESET;
	endproperty
	a_tx_unstable: assert property (p_tx_unstable) else $error("tx reset not held"); // RULE16

	property p_rx_release;
		$fell(RX_RESET) |-> $past(stable[RX_IDX], 1) && $past(stable[RX_IDX], 2);
	endproperty
	a_rx_release: assert property (p_rx_release) else $error("rx released unstable"); // RULE16

	property p_tx_min_hold;
		$fell(TX_RESET) |-> $past(tx_held) >= SETTLE_LAST;
	endproperty
	a_tx_min_hold: assert property (p_tx_min_hold) else $error("tx reset too short"); // RULE19

	property p_rx_min_hold;
		$fell(RX_RESET) |-> $past(rx_held) >= SETTLE_LAST;
	endproperty
	a_rx_min_hold: assert property (p_rx_min_hold) else $error("rx reset too short"); // RULE19

	property p_ctl_in_reset;
		$changed(CTL_OUT) |-> TX_RESET && RX_RESET && $past(TX_RESET) && $past(RX_RESET);
	endproperty
	a_ctl_in_reset: assert property (p_ctl_in_reset) else $error("control moved live"); // RULE18

	property p_ctl_settle;
		$changed(CTL_OUT) |-> ##1 (TX_RESET && RX_RESET) [*8];
	endproperty
	a_ctl_settle: assert property (p_ctl_settle) else $error("reset dropped early"); // RULE18

	property p_busy_reset;
		CTL_BUSY |-> TX_RESET && RX_RESET;
	endproperty
	a_busy_reset: assert property (p_busy_reset) else $error("busy without reset"); // RULE18

	property p_busy_len;
		$rose(CTL_BUSY) |-> CTL_BUSY [*8] ##20 !CTL_BUSY;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("update length wrong"); // RULE18

	property p_apply_value;
		(CTL_REQ && !CTL_BUSY) |-> ##15 (CTL_OUT == $past(CTL_VALUE, 15));
	endproperty
	a_apply_value: assert property (p_apply_value) else $error("wrong control applied"); // RULE18

	property p_rx_unstable;
		!stable[RX_IDX] |=> RX_RESET;
	endproperty
	a_rx_unstable: assert property (p_rx_unstable) else $error("rx reset not held"); // RULE16

	property p_tx_release;
		$fell(TX_RESET) |-> $past(stable[TX_IDX], 1) && $past(stable[TX_IDX], 2);
	endproperty
	a_tx_release: assert property (p_tx_release) else $error("tx released unstable"); // RULE16

	property p_ctl_idle;
		!CTL_BUSY |=> $stable(CTL_OUT);
	endproperty
	a_ctl_idle: assert property (p_ctl_idle) else $error("control moved while idle"); // RULE18

	property p_req_taken;
		(CTL_REQ && !CTL_BUSY) |=> CTL_BUSY && TX_RESET && RX_RESET;
	endproperty
	a_req_taken: assert property (p_req_taken) else $error("request not taken"); // RULE18

	property p_busy_not_ready;
		CTL_BUSY |-> !TX_READY && !RX_READY;
	endproperty
	a_busy_not_ready: assert property (p_busy_not_ready) else $error("ready during update"); // RULE18
endmodule

/* File: sim/ecr_dev_model.sv */
/*
 Behavioural model of the subsystem's reset side: it takes the two path resets
 and the reset-only controls. Assumes the bench commands clock quality.
*/
module ecr_dev_model
	import ecr_pkg::*;
(
	// Clock, device resets and controls
	input wire logic clk,
	input wire logic tx_reset,
	input wire logic rx_reset,
	input wire logic [ecr_pkg::CTL_W-1:0] ctl_in,
	// Clock quality commands
	input wire logic drop_tx,
	input wire logic drop_rx,
	// Indicators and findings
	output logic tx_clk_stable,
	output logic rx_clk_stable,
	output logic ctl_err,
	output logic [1:0] in_reset
);
	import ecr_pkg::*;
	logic [CTL_W-1:0] ctl_q;

	// ------------------------------------------------------------
	// Clock quality and reset capture
	// ------------------------------------------------------------
	initial begin
		ctl_err = 1'b0;
		in_reset = 2'b11;
		ctl_q = '0;
	end
	assign tx_clk_stable = ~drop_tx;
	assign rx_clk_stable = ~drop_rx;
	// A path only counts as reset once an edge has seen its reset high.
	always @(posedge clk) begin
		in_reset[TX_IDX] <= tx_reset;
		in_reset[RX_IDX] <= rx_reset;
		ctl_q <= ctl_in;
		if (ctl_in !== ctl_q && !(tx_reset || rx_reset)) begin
			ctl_err <= 1'b1;
		end
	end
endmodule

/* File: sim/eth_subsystem_clock_reset_bench.sv */
/*
 Self-checking bench for the host reset sequencer. Assumes the package
 settle and hold constants and a 125 MHz clock.
*/
module eth_subsystem_clock_reset_bench import ecr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset, ce, req, drop_tx, drop_rx, busy, tx_rst, rx_rst;
	logic tx_rdy, rx_rdy, tie, tx_st, rx_st, ctl_err;
	logic [CTL_W-1:0] val, ctl_out, v, v_old;
	logic [31:0] init_f, neg_f, seed;
	logic [1:0] in_rst;
	int errors, checks, cyc, n;

	// ------------------------------------------------------------
	// Design, model and helpers
	// ------------------------------------------------------------
	ecr_host_ctrl dut_u (.CLK(clk), .RESET(reset), .CE(ce), .TX_CLK_STABLE(tx_st),
		.RX_CLK_STABLE(rx_st), .CTL_REQ(req), .CTL_VALUE(val), .CTL_BUSY(busy),
		.TX_RESET(tx_rst), .RX_RESET(rx_rst), .CTL_OUT(ctl_out), .TX_READY(tx_rdy),
		.RX_READY(rx_rdy), .INIT_CLK_FREQ(init_f), .NEG_CLK_FREQ(neg_f), .CLK_TIE_SEL(tie));
	ecr_dev_model dev_u (.clk(clk), .tx_reset(tx_rst), .rx_reset(rx_rst), .ctl_in(ctl_out),
		.drop_tx(drop_tx), .drop_rx(drop_rx), .tx_clk_stable(tx_st), .rx_clk_stable(rx_st),
		.ctl_err(ctl_err), .in_reset(in_rst));
	always #4 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// Sync delay plus the full settle count plus a small margin.
	function automatic int settle_lim();
		return SETTLE_CYC + 16;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic wait_ready();
		n = 0;
		while (!(tx_rdy === 1'b1 && rx_rdy === 1'b1) && n < settle_lim()) begin
			tick();
			n++;
		end
		check(n < settle_lim(), 1'b1);
		// The model captures the resets one edge late.
		tick();
		check(in_rst, 2'b00);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			finish_test();
		end
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		ce = 1'b1;
		req = 1'b0;
		val = '0;
		drop_tx = 1'b0;
		drop_rx = 1'b0;
		seed = 32'h8CA9DAA2;
		errors = 0;
		checks = 0;
		cyc = 0;
		repeat (8) tick();
		check({tx_rst, rx_rst, busy, tx_rdy, rx_rdy}, 5'h18);
		check(ctl_out, CTL_RESET);
		@(posedge clk) reset <= 1'b0;
		check(init_f, 32'h047868C0);
		check(neg_f, 32'h047868C0);
		check(tie, 1'b1);
		repeat (SETTLE_CYC - 20) tick();
		check({tx_rst, rx_rst}, 2'h3);
		wait_ready();
		// Drop one clock at a time: only that path may go back into reset.
		for (int i = 0; i < 2; i++) begin
			seed = xs(seed);
			@(posedge clk) begin
				drop_tx <= (i == 0);
				drop_rx <= (i == 1);
			end
			repeat (8 + seed[2:0]) tick();
			check({tx_rst, rx_rst}, (i == 0) ? 2'h2 : 2'h1);
			@(posedge clk) {drop_tx, drop_rx} <= 2'b00;
			wait_ready();
		end
		// Updates, some back to back, each with an ignored request mid-run.
		for (int k = 0; k < 4; k++) begin
			seed = xs(seed);
			v = (k == 0) ? 8'hFF : seed[7:0];
			@(posedge clk) begin
				req <= 1'b1;
				val <= v;
			end
			@(posedge clk) req <= 1'b0;
			tick();
			check({busy, tx_rst, rx_rst}, 3'h7);
			repeat (5) tick();
			@(posedge clk) begin
				req <= 1'b1;
				val <= ~v;
			end
			@(posedge clk) req <= 1'b0;
			n = 0;
			while (busy !== 1'b0 && n < 40) begin
				tick();
				n++;
			end
			check(n < 40, 1'b1);
			check(ctl_out, v);
			check(ctl_err, 1'b0);
			if (k[0]) begin
				wait_ready();
				check(ctl_out, v);
			end
		end
		// A low enable freezes an update part way; the old value stands until it returns.
		seed = xs(seed);
		v_old = v;
		v = ~v;
		@(posedge clk) begin
			req <= 1'b1;
			val <= v;
		end
		@(posedge clk) begin
			req <= 1'b0;
			ce <= 1'b0;
		end
		repeat (20 + seed[3:0]) tick();
		check({busy, tx_rst, rx_rst}, 3'h7);
		check(ctl_out, v_old);
		@(posedge clk) ce <= 1'b1;
		n = 0;
		while (busy !== 1'b0 && n < 40) begin
			tick();
			n++;
		end
		check(n < 40, 1'b1);
		check(ctl_out, v);
		// A reset in mid-update abandons it; a request may follow on the first edge after.
		seed = xs(seed);
		v = seed[7:0];
		@(posedge clk) begin
			req <= 1'b1;
			val <= ~v;
		end
		@(posedge clk) req <= 1'b0;
		repeat (5) tick();
		@(posedge clk) reset <= 1'b1;
		repeat (2) tick();
		check({tx_rst, rx_rst, busy, tx_rdy, rx_rdy}, 5'h18);
		check(ctl_out, CTL_RESET);
		@(posedge clk) begin
			reset <= 1'b0;
			req <= 1'b1;
			val <= v;
		end
		@(posedge clk) req <= 1'b0;
		tick();
		check({busy, tx_rst, rx_rst}, 3'h7);
		n = 0;
		while (busy !== 1'b0 && n < 40) begin
			tick();
			n++;
		end
		check(n < 40, 1'b1);
		check(ctl_out, v);
		check(ctl_err, 1'b0);
		wait_ready();
		finish_test();
	end
endmodule
